// file: hdl/codec_irq_pkg.sv
package codec_irq_pkg;

   localparam logic [7:0] ADDR_STICKY_OVF = 8'h2a;
   localparam logic [7:0] ADDR_STICKY_MIX = 8'h2c;
   localparam logic [7:0] ADDR_STICKY_SPK = 8'h2d;
   localparam logic [7:0] ADDR_FIRST_EN   = 8'h30;
   localparam logic [7:0] ADDR_SECOND_EN  = 8'h31;
   localparam logic [7:0] ADDR_CONV_CTL   = 8'h32;
   localparam logic [7:0] ADDR_FMT        = 8'h33;

   localparam logic [7:0] RST_FIRST_EN  = 8'h00;
   localparam logic [7:0] RST_SECOND_EN = 8'h00;
   localparam logic [7:0] RST_CONV_CTL  = 8'h00;
   localparam logic [7:0] RST_FMT       = 8'h00;

   localparam logic [7:0] WMASK_EN   = 8'hfe;
   localparam logic [7:0] WMASK_CONV = 8'hf0;
   localparam logic [7:0] WMASK_FMT  = 8'hf0;

   localparam int EN_HS_BIT     = 7;
   localparam int EN_BTN_BIT    = 6;
   localparam int EN_DRC_BIT    = 5;
   localparam int EN_AGC_BIT    = 4;
   localparam int EN_OVC_BIT    = 3;
   localparam int EN_OVF_BIT    = 2;
   localparam int EN_SPK_BIT    = 1;
   localparam int SAR_RANGE1_BIT = 7;
   localparam int SAR_AVAIL1_BIT = 6;
   localparam int SAR_RANGE2_BIT = 5;
   localparam int SAR_AVAIL2_BIT = 4;
   localparam int FMT_FIRST_LSB  = 6;
   localparam int FMT_SECOND_LSB = 4;

   localparam logic [1:0] SHAPE_PULSE  = 2'h0;
   localparam logic [1:0] SHAPE_TRAIN  = 2'h1;
   localparam logic [1:0] SHAPE_STICKY = 2'h2;
   localparam logic [1:0] SHAPE_LIVE   = 2'h3;

   localparam int CLK_FREQ_KHZ   = 125000;
   localparam int PULSE_TIME_US  = 2000;
   localparam int PERIOD_TIME_US = 4000;
   localparam int PULSE_CYCLES   = (PULSE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
   localparam int PERIOD_CYCLES  = (PERIOD_TIME_US * CLK_FREQ_KHZ) / 1000;

   typedef enum logic [2:0] {
      SH_IDLE = 3'b001,
      SH_HIGH = 3'b010,
      SH_GAP  = 3'b100
   } shaper_state_t;

endpackage

// file: hdl/sticky_flags.sv
`timescale 1ns/1ns
`default_nettype none
module sticky_flags #(
   parameter int W = 4
) (
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] set_in,
   input  wire logic         clr,
   output logic      [W-1:0] flags
);
   typedef struct packed {
      logic [W-1:0] flags;
   } sticky_st_t;

   sticky_st_t cur_ff;
   sticky_st_t nxt_st;

   // A set in the clearing cycle wins over the clear.
   always_comb begin
      nxt_st       = cur_ff;
      nxt_st.flags = (cur_ff.flags & ~{W{clr}}) | set_in;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign flags = cur_ff.flags;

   chk_set_wins : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (clr && set_in != '0) |=> ((flags & $past(set_in)) == $past(set_in)))
      else $error("Sticky set lost against a clear.");
endmodule
`default_nettype wire

// file: hdl/irq_shaper.sv
`timescale 1ns/1ns
`default_nettype none
module irq_shaper
   import codec_irq_pkg::*;
#(
   parameter int PULSE_CYC  = PULSE_CYCLES,
   parameter int PERIOD_CYC = PERIOD_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic [1:0] shape,
   input  wire logic       live,
   input  wire logic       sticky_any,
   input  wire logic       stop,
   output logic            irq
);
   localparam int CW = $clog2(PERIOD_CYC + 1);

   typedef struct packed {
      shaper_state_t st;
      logic [CW-1:0] cnt;
      logic          live_q;
      logic          stop_pend;
      logic          irq;
   } shaper_st_t;

   shaper_st_t cur_ff;
   shaper_st_t nxt_st;
   logic       rise;

   always_comb begin
      nxt_st           = cur_ff;
      rise             = live & ~cur_ff.live_q;
      nxt_st.live_q    = live;
      nxt_st.stop_pend = cur_ff.stop_pend | stop;
      if (shape == SHAPE_PULSE || shape == SHAPE_TRAIN) begin
         case (cur_ff.st)
            SH_IDLE: begin
               if (rise) begin
                  nxt_st.st        = SH_HIGH;
                  nxt_st.cnt       = '0;
                  nxt_st.stop_pend = 1'b0;
               end
            end
            SH_HIGH: begin
               nxt_st.cnt = cur_ff.cnt + 1'b1;
               if (cur_ff.cnt == CW'(PULSE_CYC - 1)) begin
                  if (shape == SHAPE_TRAIN && !nxt_st.stop_pend) begin
                     nxt_st.st = SH_GAP;
                  end else begin
                     nxt_st.st = SH_IDLE;
                  end
               end
            end
            SH_GAP: begin
               nxt_st.cnt = cur_ff.cnt + 1'b1;
               if (nxt_st.stop_pend || shape != SHAPE_TRAIN) begin
                  nxt_st.st = SH_IDLE;
               end else if (cur_ff.cnt == CW'(PERIOD_CYC - 1)) begin
                  nxt_st.st  = SH_HIGH;
                  nxt_st.cnt = '0;
               end
            end
            default: begin
               nxt_st.st = SH_IDLE;
            end
         endcase
         nxt_st.irq = (nxt_st.st == SH_HIGH);
      end else begin
         nxt_st.st  = SH_IDLE;
         nxt_st.cnt = '0;
         nxt_st.irq = (shape == SHAPE_STICKY) ? sticky_any : live;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_ff     <= '0;
         cur_ff.st  <= SH_IDLE;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign irq = cur_ff.irq;

   // Counts how long the output has been high, for the width check.
   logic [CW-1:0] hi_len_ff;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hi_len_ff <= '0;
      end else begin
         hi_len_ff <= irq ? hi_len_ff + 1'b1 : '0;
      end
   end

   chk_pulse_width : assert property (@(posedge ref_clk) disable iff (sys_rst)
      ($fell(irq) && $past(cur_ff.st) == SH_HIGH) |-> (hi_len_ff == CW'(PULSE_CYC)))
      else $error("Interrupt pulse width differs from the pulse time.");
   chk_train_repeat : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cur_ff.st == SH_GAP && shape == SHAPE_TRAIN && !cur_ff.stop_pend && !stop &&
       cur_ff.cnt == CW'(PERIOD_CYC - 1)) |=> irq)
      else $error("Pulse train did not restart at the period.");
   chk_sticky_level : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shape == SHAPE_STICKY) |=> (irq == $past(sticky_any)))
      else $error("Sticky level output does not follow the flags.");
endmodule
`default_nettype wire

// file: hdl/codec_interrupt_routing.sv
// Behaviour
// - Headset insertion drives the second output when its enable bit is set.
// - Button press drives the second output when its enable bit is set.
// - DRC threshold on either channel drives the second output when enabled.
// - AGC noise on either channel drives the second output when enabled.
// - Headphone over-current on either channel drives the second output when enabled.
// - ADC or DAC overflow drives the second output when enabled.
// - Speaker over-temperature joins the second output only when enabled.
// - SAR out-of-range feeds first output via bit 7, second via bit 5.
// - SAR data-available feeds first output via bit 6, second via bit 4.
// - SAR data-available sticky flag sets on event, clears on register read.
// - SAR out-of-range sticky flag sets on event, clears on register read.
// - First output shape is format bits 7:6, reset to single pulse.
// - Shape 00 on first output gives one high pulse of at least 2 ms.
// - Shape 01 gives repeated 2 ms pulses every 4 ms until a flag read.
// - Shape 10 gives a level from sticky flags, dropping after flag reads.
// - Shape 11 gives a level following the live combined sources.
// - Second output shape is format bits 5:4, reset to 00.
// - Shape 00 on second output gives one high pulse of about 2 ms.
// - Shape 01 on second output repeats 2 ms pulses until a flag read.
// - Overflow sticky flags hold any overflow since last read, clear on read.
// - A separate enable register gates the same sources onto the first output.
`timescale 1ns/1ns
`default_nettype none
module codec_interrupt_routing #(
   parameter int PULSE_CYC  = codec_irq_pkg::PULSE_CYCLES,
   parameter int PERIOD_CYC = codec_irq_pkg::PERIOD_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       hs_insert_evt,
   input  wire logic       button_evt,
   input  wire logic       drc_left_evt,
   input  wire logic       drc_right_evt,
   input  wire logic       agc_left_evt,
   input  wire logic       agc_right_evt,
   input  wire logic       ovc_left_evt,
   input  wire logic       ovc_right_evt,
   input  wire logic       dac_left_ovf_evt,
   input  wire logic       dac_right_ovf_evt,
   input  wire logic       adc_left_ovf_evt,
   input  wire logic       adc_right_ovf_evt,
   input  wire logic       spk_overtemp_evt,
   input  wire logic       sar_avail_evt,
   input  wire logic       sar_range_evt,
   output logic            irq_out_first,
   output logic            irq_out_second
);
   import codec_irq_pkg::*;

   typedef struct packed {
      logic [7:0] first_en;
      logic [7:0] second_en;
      logic [7:0] conv_ctl;
      logic [7:0] fmt;
      logic [7:0] rdata;
   } regs_st_t;

   regs_st_t cur_ff;
   regs_st_t nxt_st;

   logic [3:0] ovf_set;
   logic [3:0] ovf_flags;
   logic [5:0] mix_set;
   logic [5:0] mix_flags;
   logic [2:0] spk_set;
   logic [2:0] spk_flags;
   logic [1:0] sar_set;
   logic [1:0] sar_flags;
   logic       rd_ovf;
   logic       rd_mix;
   logic       rd_spk;
   logic       rd_sar;
   logic       flag_read;
   logic [7:1] src_live;
   logic [7:1] src_sticky;
   logic       live_first;
   logic       live_second;
   logic       sticky_first;
   logic       sticky_second;
   logic [1:0] shape_first;
   logic [1:0] shape_second;
   logic       irq_first;
   logic       irq_second;

   // Sticky flag groups and their read-clear strobes.
   assign ovf_set = {dac_left_ovf_evt, dac_right_ovf_evt, adc_left_ovf_evt, adc_right_ovf_evt};
   assign mix_set = {ovc_left_evt, ovc_right_evt, button_evt, hs_insert_evt,
                     drc_left_evt, drc_right_evt};
   assign spk_set = {spk_overtemp_evt, agc_left_evt, agc_right_evt};
   assign sar_set = {sar_avail_evt, sar_range_evt};

   assign rd_ovf    = reg_rd && reg_addr == ADDR_STICKY_OVF;
   assign rd_mix    = reg_rd && reg_addr == ADDR_STICKY_MIX;
   assign rd_spk    = reg_rd && reg_addr == ADDR_STICKY_SPK;
   assign rd_sar    = reg_rd && reg_addr == ADDR_CONV_CTL;
   assign flag_read = rd_ovf || rd_mix || rd_spk;

   sticky_flags #(.W(4)) u_ovf_flags (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_in  (ovf_set),
      .clr     (rd_ovf),
      .flags   (ovf_flags)
   );

   sticky_flags #(.W(6)) u_mix_flags (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_in  (mix_set),
      .clr     (rd_mix),
      .flags   (mix_flags)
   );

   sticky_flags #(.W(3)) u_spk_flags (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_in  (spk_set),
      .clr     (rd_spk),
      .flags   (spk_flags)
   );

   sticky_flags #(.W(2)) u_sar_flags (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_in  (sar_set),
      .clr     (rd_sar),
      .flags   (sar_flags)
   );

   // Source vectors share the bit positions of the enable registers.
   assign src_live = {hs_insert_evt,
                      button_evt,
                      drc_left_evt | drc_right_evt,
                      agc_left_evt | agc_right_evt,
                      ovc_left_evt | ovc_right_evt,
                      |ovf_set,
                      spk_overtemp_evt};
   assign src_sticky = {mix_flags[2],
                        mix_flags[3],
                        mix_flags[1] | mix_flags[0],
                        spk_flags[1] | spk_flags[0],
                        mix_flags[5] | mix_flags[4],
                        |ovf_flags,
                        spk_flags[2]};

   // Enabled sources are ORed into one live trigger and one sticky level per output.
   assign live_first    = |(src_live & cur_ff.first_en[7:1])
                          | (sar_range_evt & cur_ff.conv_ctl[SAR_RANGE1_BIT])
                          | (sar_avail_evt & cur_ff.conv_ctl[SAR_AVAIL1_BIT]);
   assign live_second   = |(src_live & cur_ff.second_en[7:1])
                          | (sar_range_evt & cur_ff.conv_ctl[SAR_RANGE2_BIT])
                          | (sar_avail_evt & cur_ff.conv_ctl[SAR_AVAIL2_BIT]);
   assign sticky_first  = |(src_sticky & cur_ff.first_en[7:1])
                          | (sar_flags[0] & cur_ff.conv_ctl[SAR_RANGE1_BIT])
                          | (sar_flags[1] & cur_ff.conv_ctl[SAR_AVAIL1_BIT]);
   assign sticky_second = |(src_sticky & cur_ff.second_en[7:1])
                          | (sar_flags[0] & cur_ff.conv_ctl[SAR_RANGE2_BIT])
                          | (sar_flags[1] & cur_ff.conv_ctl[SAR_AVAIL2_BIT]);

   assign shape_first  = cur_ff.fmt[FMT_FIRST_LSB +: 2];
   assign shape_second = cur_ff.fmt[FMT_SECOND_LSB +: 2];

   irq_shaper #(
      .PULSE_CYC  (PULSE_CYC),
      .PERIOD_CYC (PERIOD_CYC)
   ) u_shape_first (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .shape      (shape_first),
      .live       (live_first),
      .sticky_any (sticky_first),
      .stop       (flag_read),
      .irq        (irq_first)
   );

   irq_shaper #(
      .PULSE_CYC  (PULSE_CYC),
      .PERIOD_CYC (PERIOD_CYC)
   ) u_shape_second (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .shape      (shape_second),
      .live       (live_second),
      .sticky_any (sticky_second),
      .stop       (flag_read),
      .irq        (irq_second)
   );

   // Register writes keep only writable bits; reads return the value before any clear.
   always_comb begin
      nxt_st = cur_ff;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_FIRST_EN:  nxt_st.first_en  = reg_wdata & WMASK_EN;
            ADDR_SECOND_EN: nxt_st.second_en = reg_wdata & WMASK_EN;
            ADDR_CONV_CTL:  nxt_st.conv_ctl  = reg_wdata & WMASK_CONV;
            ADDR_FMT:       nxt_st.fmt       = reg_wdata & WMASK_FMT;
            default:        nxt_st.fmt       = cur_ff.fmt;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            ADDR_STICKY_OVF: nxt_st.rdata = {ovf_flags[3:2], 2'b00, ovf_flags[1:0], 2'b00};
            ADDR_STICKY_MIX: nxt_st.rdata = {mix_flags, 2'b00};
            ADDR_STICKY_SPK: nxt_st.rdata = {spk_flags, 5'b00000};
            ADDR_FIRST_EN:   nxt_st.rdata = cur_ff.first_en;
            ADDR_SECOND_EN:  nxt_st.rdata = cur_ff.second_en;
            ADDR_CONV_CTL:   nxt_st.rdata = {cur_ff.conv_ctl[7:4], 1'b0, sar_flags, 1'b0};
            ADDR_FMT:        nxt_st.rdata = cur_ff.fmt;
            default:         nxt_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_ff.first_en  <= RST_FIRST_EN;
         cur_ff.second_en <= RST_SECOND_EN;
         cur_ff.conv_ctl  <= RST_CONV_CTL;
         cur_ff.fmt       <= RST_FMT;
         cur_ff.rdata     <= 8'h00;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign reg_rdata      = cur_ff.rdata;
   assign irq_out_first  = irq_first;
   assign irq_out_second = irq_second;

   // Checks on routing in the live shape, where the output follows one cycle later.
   sequence live_second_s;
      shape_second == SHAPE_LIVE;
   endsequence

   chk_insert_second : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (live_second_s and (cur_ff.second_en[EN_HS_BIT] && hs_insert_evt)) |=> irq_out_second)
      else $error("Enabled insertion did not raise the second output.");

   chk_button_second : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (live_second_s and (cur_ff.second_en[EN_BTN_BIT] && button_evt)) |=> irq_out_second)
      else $error("Enabled button press did not raise the second output.");

   chk_drc_second : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (live_second_s and (cur_ff.second_en[EN_DRC_BIT] && (drc_left_evt || drc_right_evt)))
      |=> irq_out_second)
      else $error("Enabled DRC threshold did not raise the second output.");

   chk_agc_second : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (live_second_s and (cur_ff.second_en[EN_AGC_BIT] && (agc_left_evt || agc_right_evt)))
      |=> irq_out_second)
      else $error("Enabled AGC noise did not raise the second output.");

   chk_ovc_second : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (live_second_s and (cur_ff.second_en[EN_OVC_BIT] && (ovc_left_evt || ovc_right_evt)))
      |=> irq_out_second)
      else $error("Enabled over-current did not raise the second output.");

   chk_ovf_second : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (live_second_s and (cur_ff.second_en[EN_OVF_BIT] && (|ovf_set))) |=> irq_out_second)
      else $error("Enabled overflow did not raise the second output.");

   chk_spk_excluded : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (live_second_s and (!live_second && spk_overtemp_evt)) |=> !irq_out_second)
      else $error("Disabled speaker source raised the second output.");

   chk_sar_routing : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shape_first == SHAPE_LIVE &&
       ((sar_range_evt && cur_ff.conv_ctl[SAR_RANGE1_BIT]) ||
        (sar_avail_evt && cur_ff.conv_ctl[SAR_AVAIL1_BIT]))) |=> irq_out_first)
      else $error("Enabled SAR event did not raise the first output.");

   chk_sar_second : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (live_second_s and ((sar_range_evt && cur_ff.conv_ctl[SAR_RANGE2_BIT]) ||
       (sar_avail_evt && cur_ff.conv_ctl[SAR_AVAIL2_BIT]))) |=> irq_out_second)
      else $error("Enabled SAR event did not raise the second output.");

   chk_insert_first : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shape_first == SHAPE_LIVE && cur_ff.first_en[EN_HS_BIT] && hs_insert_evt)
      |=> irq_out_first)
      else $error("Enabled insertion did not raise the first output.");

   chk_ovf_first : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shape_first == SHAPE_LIVE && cur_ff.first_en[EN_OVF_BIT] && (|ovf_set))
      |=> irq_out_first)
      else $error("Enabled overflow did not raise the first output.");

   chk_spk_first : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shape_first == SHAPE_LIVE && cur_ff.first_en[EN_SPK_BIT] && spk_overtemp_evt)
      |=> irq_out_first)
      else $error("Enabled speaker source did not raise the first output.");

   chk_live_gate : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shape_first == SHAPE_LIVE && !live_first) |=> !irq_out_first)
      else $error("First output rose with no enabled live source.");

   chk_second_gate : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (live_second_s and !live_second) |=> !irq_out_second)
      else $error("Second output rose with no enabled live source.");

   // Checks on the pulse start and the sticky level of the second output.
   chk_pulse_start : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shape_second == SHAPE_PULSE && !irq_out_second && live_second && !$past(live_second))
      |=> irq_out_second)
      else $error("Enabled rise did not start a second output pulse.");

   chk_sticky_second : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shape_second == SHAPE_STICKY) |=> (irq_out_second == $past(sticky_second)))
      else $error("Second sticky level does not follow the flags.");

   // Checks on read-clear of the flags and on reserved bits.
   chk_sar_sticky : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (rd_sar && !sar_avail_evt && !sar_range_evt) |=> (sar_flags == 2'b00)
      ##1 (!$past(sar_avail_evt) || sar_flags[1]))
      else $error("SAR sticky flags did not clear on read or set on event.");

   chk_ovf_clear : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (rd_ovf && ovf_set == 4'h0) |=> (ovf_flags == 4'h0))
      else $error("Overflow sticky flags survived a read.");

   chk_mix_clear : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (rd_mix && mix_set == 6'h00) |=> (mix_flags == 6'h00))
      else $error("Mixed sticky flags survived a read.");

   chk_spk_clear : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (rd_spk && spk_set == 3'h0) |=> (spk_flags == 3'h0))
      else $error("Speaker sticky flags survived a read.");

   chk_reserved_zero : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == ADDR_FMT) |=> (reg_rdata[3:0] == 4'h0))
      else $error("Reserved format bits did not read zero.");

   chk_reserved_en : assert property (@(posedge ref_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == ADDR_SECOND_EN) |=> !reg_rdata[0])
      else $error("Reserved enable bit did not read zero.");
endmodule
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model
   import codec_irq_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       irq_out_first,
   input  wire logic       irq_out_second,
   input  wire logic       svc_en,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_wdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
      @(posedge ref_clk);
      #1;
      d = reg_rdata;
   endtask
   // Services a raised interrupt by reading the mixed flag register, which ends trains and the sticky levels its flags raise.
   always begin
      logic [7:0] junk;
      wait (svc_en && (irq_out_first || irq_out_second));
      rd(ADDR_STICKY_MIX, junk);
   end
endmodule
`default_nettype wire

// file: tb/codec_interrupt_routing_tb.sv
`timescale 1ns/1ns
`default_nettype none
module codec_interrupt_routing_tb;
   import codec_irq_pkg::*;
   localparam int PC = 8;
   logic        ref_clk;
   logic        sys_rst;
   logic        svc_en;
   logic [14:0] evt;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        reg_wr;
   logic        reg_rd;
   logic        irq_out_first;
   logic        irq_out_second;
   logic [7:0]  d;
   logic [7:0]  a;
   logic [7:0]  b;
   int          num_errors = 0;
   int          total_checks = 0;
   int          hi1;
   int          hi2;
   logic [7:0]  fa [7] = '{8'h2a, 8'h2c, 8'h2d, 8'h32, 8'h30, 8'h31, 8'h33};
   logic [7:0]  fx [4] = '{8'hcc, 8'hfc, 8'he0, 8'h06};
   logic [7:0]  wa [6] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h2c, 8'h3c};
   logic [7:0]  wx [6] = '{8'hfe, 8'hfe, 8'hf0, 8'hf0, 8'h00, 8'h00};
   int          en_map [13] = '{7, 6, 5, 5, 4, 4, 3, 3, 2, 2, 2, 2, 1};

   codec_interrupt_routing #(.PULSE_CYC(PC), .PERIOD_CYC(2 * PC)) uut (
      .ref_clk           (ref_clk),
      .sys_rst           (sys_rst),
      .reg_addr          (reg_addr),
      .reg_wr            (reg_wr),
      .reg_rd            (reg_rd),
      .reg_wdata         (reg_wdata),
      .reg_rdata         (reg_rdata),
      .hs_insert_evt     (evt[0]),
      .button_evt        (evt[1]),
      .drc_left_evt      (evt[2]),
      .drc_right_evt     (evt[3]),
      .agc_left_evt      (evt[4]),
      .agc_right_evt     (evt[5]),
      .ovc_left_evt      (evt[6]),
      .ovc_right_evt     (evt[7]),
      .dac_left_ovf_evt  (evt[8]),
      .dac_right_ovf_evt (evt[9]),
      .adc_left_ovf_evt  (evt[10]),
      .adc_right_ovf_evt (evt[11]),
      .spk_overtemp_evt  (evt[12]),
      .sar_avail_evt     (evt[13]),
      .sar_range_evt     (evt[14]),
      .irq_out_first     (irq_out_first),
      .irq_out_second    (irq_out_second)
   );
   host_model host (
      .ref_clk        (ref_clk),
      .irq_out_first  (irq_out_first),
      .irq_out_second (irq_out_second),
      .svc_en         (svc_en),
      .reg_rdata      (reg_rdata),
      .reg_addr       (reg_addr),
      .reg_wr         (reg_wr),
      .reg_rd         (reg_rd),
      .reg_wdata      (reg_wdata)
   );

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
      host.rd(ad, d);
      chk(d, exp);
   endtask
   // Drives the headset input to lvl and counts high samples of each output.
   task automatic shot(input int n, input logic lvl);
      @(posedge ref_clk);
      #1;
      evt[0] = lvl;
      hi1 = 0;
      hi2 = 0;
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         hi1 += int'(irq_out_first === 1'b1);
         hi2 += int'(irq_out_second === 1'b1);
      end
      evt[0] = 1'b0;
   endtask
   task automatic summarize;
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #400000;
      num_errors++;
      summarize();
   end

   initial begin
      sys_rst = 1'b1;
      svc_en  = 1'b0;
      evt     = '0;
      repeat (5) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      for (int i = 0; i < 7; i++) rchk(fa[i], 8'h00);
      @(posedge ref_clk);
      #1;
      evt = '1;
      @(posedge ref_clk);
      #1;
      evt = '0;
      for (int i = 0; i < 4; i++) rchk(fa[i], fx[i]);
      for (int i = 0; i < 4; i++) rchk(fa[i], 8'h00);
      for (int i = 0; i < 6; i++) begin
         host.wr(wa[i], 8'hff);
         rchk(wa[i], wx[i]);
      end
      host.wr(8'h30, 8'h00);
      host.wr(8'h31, 8'h00);
      host.wr(8'h33, 8'hf0);
      for (int s = 0; s < 15; s++) begin
         for (int o = 0; o < 2; o++) begin
            a = (s > 12) ? 8'h32 : (o == 1 ? 8'h31 : 8'h30);
            b = (s > 12) ? 8'h01 << (4 + (s == 14) + 2 * (1 - o)) : 8'h01 << en_map[s];
            for (int e = 0; e < 2; e++) begin
               host.wr(a, e == 1 ? b : 8'h00);
               @(posedge ref_clk);
               #1;
               evt[s] = 1'b1;
               @(posedge ref_clk);
               #1;
               evt[s] = 1'b0;
               chk({6'h00, irq_out_second, irq_out_first}, 8'(e << o));
            end
            host.wr(a, 8'h00);
         end
      end
      host.wr(8'h33, 8'h00);
      host.wr(8'h30, 8'h80);
      host.wr(8'h31, 8'h80);
      shot(20, 1'b1);
      chk(8'(hi1), 8'(PC));
      chk(8'(hi2), 8'(PC));
      host.wr(8'h33, 8'h50);
      shot(48, 1'b1);
      chk(8'(hi1), 8'(3 * PC));
      chk(8'(hi2), 8'(3 * PC));
      svc_en = 1'b1;
      repeat (3 * PC) @(posedge ref_clk);
      #1;
      svc_en = 1'b0;
      shot(32, 1'b0);
      chk(8'(hi1 + hi2), 8'h00);
      host.wr(8'h33, 8'ha0);
      shot(4, 1'b1);
      shot(10, 1'b0);
      chk(8'(hi1 + hi2), 8'h14);
      svc_en = 1'b1;
      repeat (10) @(posedge ref_clk);
      #1;
      svc_en = 1'b0;
      shot(4, 1'b0);
      chk({6'h00, irq_out_second, irq_out_first}, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
